//--- hdl/bus_clk_divider.sv
// glitch-free programmable bus clock divider
`timescale 1ns/1ps
`default_nettype none
module bus_clk_divider
  import clk_ctrl_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic       bypass,
  input  wire logic [3:0] half_cnt,
  output logic            clk_en,
  output logic            clk_lvl
);

  logic [3:0] cnt_r;
  logic [3:0] cur_half_r;
  logic       cur_byp_r;
  logic       lvl_r;
  logic       wrap;

  assign wrap    = (cnt_r == cur_half_r);
  assign clk_lvl = lvl_r;
  // one pulse per bus clock period, taken at each high half end
  assign clk_en  = run & (cur_byp_r | (wrap & lvl_r));

  // ==========================================================
  // ratio changes are adopted only at the end of a full period,
  // so no shortened pulse appears
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_r      <= 4'h0;
      cur_half_r <= DIV8_HALF;
      cur_byp_r  <= 1'b0;
      lvl_r      <= 1'b0;
    end
    else if (ce && run)
    begin
      if (cur_byp_r || (wrap && lvl_r))
      begin
        cnt_r      <= 4'h0;
        cur_half_r <= half_cnt;
        cur_byp_r  <= bypass;
        lvl_r      <= 1'b0;
      end
      else if (wrap)
      begin
        cnt_r <= 4'h0;
        lvl_r <= 1'b1;
      end
      else
        cnt_r <= cnt_r + 4'h1;
    end
  end

endmodule
`default_nettype wire

//--- hdl/clk_ctrl_pkg.sv
// constants for the system clock and power control block
`default_nettype none
package clk_ctrl_pkg;

  // ==========================================================
  // register byte addresses (AXI4-Lite)
  localparam logic [7:0] ADDR_CTRL0    = 8'h00; // system clock control 0
  localparam logic [7:0] ADDR_CTRL1    = 8'h04; // system clock control 1
  localparam logic [7:0] ADDR_DISP     = 8'h08; // display clock control
  localparam logic [7:0] ADDR_STATUS   = 8'h0C; // power state, read only
  localparam logic [7:0] ADDR_CMD      = 8'h10; // wait command strobe

  // ==========================================================
  // field positions
  localparam int CTRL0_WAIT_PSTOP = 2; // peripheral stop in wait
  localparam int CTRL0_MAIN_STOP  = 5; // main clock stop
  localparam int CTRL0_DIVSEL0    = 6; // divider select bit 0
  localparam int CTRL1_ALL_STOP   = 0; // all-clock stop
  localparam int CTRL1_DRIVE      = 5; // oscillator drive select
  localparam int CTRL1_DIVLO      = 6; // divider select low
  localparam int CTRL1_DIVHI      = 7; // divider select high
  localparam int DISP_TYPE_LO     = 1; // display oscillator type
  localparam int CMD_WAIT         = 0; // wait instruction strobe

  // ==========================================================
  // reset values
  localparam logic [7:0] CTRL0_RST = 8'h40;
  localparam logic [7:0] CTRL1_RST = 8'h20;
  localparam logic [7:0] DISP_RST  = 8'h00;

  // ==========================================================
  // divide ratios (as half-period counts minus one)
  localparam logic [3:0] DIV8_HALF  = 4'h3;
  localparam logic [3:0] DIV2_HALF  = 4'h0;
  localparam logic [3:0] DIV4_HALF  = 4'h1;
  localparam logic [3:0] DIV16_HALF = 4'h7;
  localparam int         PDIV_WIDTH = 5;   // free counter for 1/8/32

  // ==========================================================
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {PWR_RUN, PWR_WAIT, PWR_STOP} pwr_state_e;

endpackage
`default_nettype wire

//--- hdl/clk_power_ctrl.sv
// system clock generation and power mode control
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module clk_power_ctrl
  import clk_ctrl_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // wake-up sources
  input  wire logic              irq_pending,
  input  wire logic              irq_enabled,
  // clock and power outputs
  output logic                   main_osc_run,
  output logic                   main_osc_drive_high,
  output logic                   bus_clk_en,
  output logic                   bus_clk_level,
  output logic                   periph_clk_div1,
  output logic                   periph_clk_div8,
  output logic                   periph_clk_div32,
  output logic                   serial_clk_div1,
  output logic                   serial_clk_div8,
  output logic                   serial_clk_div32,
  output logic                   converter_clock,
  output logic                   watchdog_run,
  output logic                   port_hold,
  output logic                   irq_service,
  output logic [1:0]             display_osc_type
);

  // decode reads a full byte of address
  if (ADDR_W < 8)
  begin : g_addr_w_check
    $error("ADDR_W must be at least 8");
  end

  // ==========================================================
  // state
  logic [7:0]             ctrl0_r;
  logic [7:0]             ctrl1_r;
  logic [7:0]             disp_r;
  pwr_state_e             pwr_r;
  logic [PDIV_WIDTH-1:0]  pdiv_r;
  logic                   aw_held_r;
  logic                   w_held_r;
  logic [ADDR_W-1:0]      awaddr_r;
  logic [31:0]            wdata_r;
  logic [3:0]             wstrb_r;
  logic                   div_en;
  logic                   div_lvl;

  // ==========================================================
  // write channel decode
  logic              aw_take;
  logic              w_take;
  logic              wr_go;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0]       wr_data;
  logic              wr_lane0;
  logic              wr_ctrl0;
  logic              wr_ctrl1;
  logic              wr_disp;
  logic              wr_cmd;
  logic              wr_hit;

  assign aw_take  = s_axi_awvalid & s_axi_awready;
  assign w_take   = s_axi_wvalid & s_axi_wready;
  assign wr_go    = (aw_held_r | aw_take) & (w_held_r | w_take)
                    & ~s_axi_bvalid;
  assign wr_addr  = aw_held_r ? awaddr_r : s_axi_awaddr;
  assign wr_data  = w_held_r ? wdata_r : s_axi_wdata;
  assign wr_lane0 = w_held_r ? wstrb_r[0] : s_axi_wstrb[0];
  assign wr_ctrl0 = wr_go & wr_lane0 & (wr_addr[7:0] == ADDR_CTRL0);
  assign wr_ctrl1 = wr_go & wr_lane0 & (wr_addr[7:0] == ADDR_CTRL1);
  assign wr_disp  = wr_go & wr_lane0 & (wr_addr[7:0] == ADDR_DISP);
  assign wr_cmd   = wr_go & wr_lane0 & (wr_addr[7:0] == ADDR_CMD);
  assign wr_hit   = (wr_addr[7:0] == ADDR_CTRL0)
                  | (wr_addr[7:0] == ADDR_CTRL1)
                  | (wr_addr[7:0] == ADDR_DISP)
                  | (wr_addr[7:0] == ADDR_STATUS)
                  | (wr_addr[7:0] == ADDR_CMD);

  // ==========================================================
  // power mode events
  logic running;
  logic enter_stop;
  logic enter_wait;
  logic wake;

  assign running    = (pwr_r == PWR_RUN);
  assign enter_stop = running & wr_ctrl1 & wr_data[CTRL1_ALL_STOP];
  assign enter_wait = running & wr_cmd & wr_data[CMD_WAIT] & ~enter_stop;
  // stop needs a pre-enabled interrupt, wait any pending one
  assign wake = (pwr_r == PWR_STOP) ? (irq_pending & irq_enabled)
              : (pwr_r == PWR_WAIT) ? irq_pending : 1'b0;

  // ==========================================================
  // bus clock ratio decode
  logic [3:0] half_sel;
  logic       bypass_sel;

  assign bypass_sel = ~ctrl0_r[CTRL0_DIVSEL0]
                    & ~ctrl1_r[CTRL1_DIVHI] & ~ctrl1_r[CTRL1_DIVLO];
  assign half_sel   = ctrl0_r[CTRL0_DIVSEL0] ? DIV8_HALF :
                      ({ctrl1_r[CTRL1_DIVHI], ctrl1_r[CTRL1_DIVLO]} == 2'b01)
                      ? DIV2_HALF :
                      ({ctrl1_r[CTRL1_DIVHI], ctrl1_r[CTRL1_DIVLO]} == 2'b10)
                      ? DIV4_HALF : DIV16_HALF;

  // ==========================================================
  // clock gating terms
  logic osc_on;
  logic bus_run;
  logic per_run;

  assign osc_on  = (pwr_r != PWR_STOP) & ~ctrl0_r[CTRL0_MAIN_STOP];
  assign bus_run = osc_on & running;
  assign per_run = osc_on &
                   ~((pwr_r == PWR_WAIT) & ctrl0_r[CTRL0_WAIT_PSTOP]);

  bus_clk_divider bus_clk_divider_i
  (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ce       (ce),
    .run      (bus_run),
    .bypass   (bypass_sel),
    .half_cnt (half_sel),
    .clk_en   (div_en),
    .clk_lvl  (div_lvl)
  );

  // ==========================================================
  // peripheral clock enables from a free counter
  logic p8_tick;
  logic p32_tick;

  assign p8_tick  = (pdiv_r[2:0] == 3'h7);
  assign p32_tick = (pdiv_r == 5'h1F);

  // ==========================================================
  // control registers; stop entry from run forces drive and /8
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl0_r <= CTRL0_RST;
      ctrl1_r <= CTRL1_RST;
      disp_r  <= DISP_RST;
    end
    else if (ce)
    begin
      if (wr_ctrl0)
        ctrl0_r <= wr_data[7:0];
      else if (enter_stop)
        ctrl0_r[CTRL0_DIVSEL0] <= 1'b1;
      if (enter_stop)
        ctrl1_r <= {wr_data[7:6], 1'b1, wr_data[4:1], 1'b0};
      else if (wr_ctrl1)
        ctrl1_r <= {wr_data[7:1], 1'b0};
      if (wr_disp)
        disp_r <= wr_data[7:0];
    end
  end

  // ==========================================================
  // power state machine
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      pwr_r <= PWR_RUN;
    else if (ce)
    begin
      case (pwr_r)
        PWR_RUN:
        begin
          if (enter_stop)
            pwr_r <= PWR_STOP;
          else if (enter_wait)
            pwr_r <= PWR_WAIT;
        end
        PWR_WAIT: if (wake) pwr_r <= PWR_RUN;
        PWR_STOP: if (wake) pwr_r <= PWR_RUN;
        default:  pwr_r <= PWR_RUN;
      endcase
    end
  end

  // ==========================================================
  // output flops
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pdiv_r              <= '0;
      main_osc_run        <= 1'b1;
      main_osc_drive_high <= 1'b1;
      bus_clk_en          <= 1'b0;
      bus_clk_level       <= 1'b0;
      periph_clk_div1     <= 1'b0;
      periph_clk_div8     <= 1'b0;
      periph_clk_div32    <= 1'b0;
      serial_clk_div1     <= 1'b0;
      serial_clk_div8     <= 1'b0;
      serial_clk_div32    <= 1'b0;
      converter_clock     <= 1'b0;
      watchdog_run        <= 1'b1;
      port_hold           <= 1'b0;
      irq_service         <= 1'b0;
      display_osc_type    <= 2'b00;
    end
    else if (ce)
    begin
      if (per_run)
        pdiv_r <= pdiv_r + 5'h01;
      main_osc_run        <= osc_on;
      main_osc_drive_high <= ctrl1_r[CTRL1_DRIVE];
      bus_clk_en          <= div_en;
      bus_clk_level       <= div_lvl;
      periph_clk_div1     <= per_run;
      periph_clk_div8     <= per_run & p8_tick;
      periph_clk_div32    <= per_run & p32_tick;
      serial_clk_div1     <= per_run;
      serial_clk_div8     <= per_run & p8_tick;
      serial_clk_div32    <= per_run & p32_tick;
      converter_clock     <= per_run;
      watchdog_run        <= bus_run;
      port_hold           <= ~running & ~wake;
      irq_service         <= ~running & wake;
      display_osc_type    <= disp_r[DISP_TYPE_LO+1:DISP_TYPE_LO];
    end
  end

  // ==========================================================
  // AXI write side: address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= '0;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_awready <= ~aw_held_r & ~aw_take & ~s_axi_bvalid;
      s_axi_wready  <= ~w_held_r & ~w_take & ~s_axi_bvalid;
      if (aw_take)
        awaddr_r <= s_axi_awaddr;
      if (w_take)
      begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        s_axi_awready <= 1'b0;
        s_axi_wready  <= 1'b0;
      end
      else
      begin
        if (aw_take)
          aw_held_r <= 1'b1;
        if (w_take)
          w_held_r <= 1'b1;
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // AXI read side
  logic [31:0] rd_word;
  logic        rd_hit;
  logic [7:0]  rd_a;

  assign rd_a    = s_axi_araddr[7:0];
  assign rd_hit  = (rd_a == ADDR_CTRL0) | (rd_a == ADDR_CTRL1)
                 | (rd_a == ADDR_DISP) | (rd_a == ADDR_STATUS)
                 | (rd_a == ADDR_CMD);
  assign rd_word = (rd_a == ADDR_CTRL0)  ? {24'h0, ctrl0_r} :
                   (rd_a == ADDR_CTRL1)  ? {24'h0, ctrl1_r} :
                   (rd_a == ADDR_DISP)   ? {24'h0, disp_r} :
                   (rd_a == ADDR_STATUS) ? {30'h0, pwr_r} : 32'h0000_0000;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else if (ce)
    begin
      s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid  <= 1'b1;
        s_axi_arready <= 1'b0;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

//--- tb/clk_power_ctrl_assertions.sv
// checker for the clock and power control block
`timescale 1ns/1ps
`default_nettype none
module clk_power_ctrl_chk
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        ce,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        irq_pending,
  input wire logic        irq_enabled,
  input wire logic        main_osc_run,
  input wire logic        main_osc_drive_high,
  input wire logic        bus_clk_en,
  input wire logic        bus_clk_level,
  input wire logic        periph_clk_div1,
  input wire logic        periph_clk_div8,
  input wire logic        periph_clk_div32,
  input wire logic        serial_clk_div1,
  input wire logic        serial_clk_div8,
  input wire logic        serial_clk_div32,
  input wire logic        converter_clock,
  input wire logic        watchdog_run,
  input wire logic        port_hold,
  input wire logic        irq_service
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || !ce);

  // ==========================================================
  // sequences
  sequence div8_period;
    bus_clk_en ##1 !bus_clk_en [*7] ##1 bus_clk_en;
  endsequence
  sequence in_wait;
    port_hold && main_osc_run;
  endsequence

  // ==========================================================
  // properties
  reset_vals_a: assert property (
    $rose(aresetn) |-> main_osc_run && main_osc_drive_high && watchdog_run)
    else $error("reset state wrong");
  first_div8_a: assert property (
    $rose(aresetn) |-> ##[1:8] div8_period)
    else $error("bus clock not divided by eight after reset");
  div8_gap_a: assert property (
    periph_clk_div8 |=> !periph_clk_div8 [*7])
    else $error("divide by eight pulse too close");
  serial_match_a: assert property (
    {serial_clk_div1, serial_clk_div8, serial_clk_div32} ==
    {periph_clk_div1, periph_clk_div8, periph_clk_div32})
    else $error("serial clocks differ from peripheral clocks");
  osc_off_a: assert property (
    !main_osc_run && !$past(main_osc_run) |-> !(periph_clk_div1 ||
    periph_clk_div8 || periph_clk_div32 || converter_clock))
    else $error("peripheral clock with oscillator off");
  hold_quiet_a: assert property (
    port_hold && $past(port_hold) |-> !watchdog_run && !bus_clk_en)
    else $error("bus clock or watchdog running while held");
  stop_sticky_a: assert property (
    port_hold && !main_osc_run && !irq_enabled |=> port_hold)
    else $error("stop left without enabled interrupt");
  wait_wake_a: assert property (
    in_wait ##0 irq_pending |=> !port_hold)
    else $error("wait not left on interrupt");
  wake_service_a: assert property (
    $fell(port_hold) |-> ##[0:2] irq_service)
    else $error("no service pulse after wake");
  level_drop_a: assert property (
    bus_clk_en && bus_clk_level |=> !bus_clk_level)
    else $error("bus clock high half not ended by the period pulse");
  div32_align_a: assert property (
    periph_clk_div32 |-> periph_clk_div8)
    else $error("divide by 32 pulse off the divide by 8 grid");
  rdata_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before handshake");
endmodule

bind clk_power_ctrl clk_power_ctrl_chk clk_power_ctrl_chk_i (
  .aclk, .aresetn, .ce, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .irq_pending, .irq_enabled, .main_osc_run, .main_osc_drive_high,
  .bus_clk_en, .bus_clk_level, .periph_clk_div1, .periph_clk_div8,
  .periph_clk_div32,
  .serial_clk_div1, .serial_clk_div8, .serial_clk_div32,
  .converter_clock, .watchdog_run, .port_hold, .irq_service
);
`default_nettype wire

//--- tb/clk_power_ctrl_tb_top.sv
// self-checking bench for the clock and power control block
`timescale 1ns/1ps
`default_nettype none
module clk_power_ctrl_tb_top import clk_ctrl_pkg::*;;
  logic        aclk, aresetn, ce, irq_pending, irq_enabled;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [1:0]  s_axi_bresp, s_axi_rresp, display_osc_type;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, bus_clk_level, irq_service;
  logic        main_osc_run, main_osc_drive_high, bus_clk_en;
  logic        periph_clk_div1, periph_clk_div8, periph_clk_div32;
  logic        serial_clk_div1, serial_clk_div8, serial_clk_div32;
  logic        converter_clock, watchdog_run, port_hold;
  int          num_errors, checks, cycles, seed;
  logic [1:0]  wq[$];
  logic [33:0] rq[$];
  logic [7:0]  c1_tab [4] = '{8'h00, 8'h40, 8'hA0, 8'hC0};
  int          per_tab [4] = '{1, 2, 4, 16};

  clk_power_ctrl clk_power_ctrl_i (
    .aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .irq_pending, .irq_enabled, .main_osc_run,
    .main_osc_drive_high, .bus_clk_en, .bus_clk_level, .periph_clk_div1,
    .periph_clk_div8, .periph_clk_div32, .serial_clk_div1,
    .serial_clk_div8, .serial_clk_div32, .converter_clock, .watchdog_run,
    .port_hold, .irq_service, .display_osc_type
  );

  // ==========================================================
  // clock and hang limit
  always #12.5 aclk = ~aclk;
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      final_report();
    end
  end

  // ==========================================================
  // comparison and verdict
  task automatic check(input string what, input logic [33:0] seen,
                       input logic [33:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // ==========================================================
  // bus answers compared with the oldest note
  always @(posedge aclk)
  begin
    if (s_axi_bvalid && s_axi_bready)
      check("bresp", {30'h0, s_axi_bresp}, {30'h0, wq.pop_front()});
    if (s_axi_rvalid && s_axi_rready)
      check("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
  end

  // ==========================================================
  // bus master tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    wq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    int k;
    int dly;
    rq.push_back({r, d});
    dly = $unsigned($random(seed)) % 3;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (k == dly) s_axi_rready <= 1'b1;
      k++;
    end while (!(s_axi_rvalid && s_axi_rready));
    s_axi_rready <= 1'b0;
  endtask

  // bus clock period after the new ratio settles
  task automatic period(input int exp);
    int n;
    repeat (4)
    begin
      n = 0;
      do
      begin
        @(posedge aclk);
        n++;
      end while (!bus_clk_en && n < 40);
    end
    check("bus clock period", n, exp);
  endtask
  // raise a request and wait for the service pulse
  task automatic wake();
    int n;
    n = 0;
    irq_pending <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
    end while (irq_service !== 1'b1 && n < 10);
    irq_pending <= 1'b0;
    irq_enabled <= 1'b0;
    check("irq service", {31'h0, irq_service}, 32'h1);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] d;
    aclk = 1'b0;
    aresetn = 1'b0;
    ce = 1'b1;
    {irq_pending, irq_enabled, s_axi_awvalid, s_axi_wvalid} = 4'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    seed = 24;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    // reset contents, status and an unmapped place
    rd(ADDR_CTRL0, {24'h0, CTRL0_RST}, RESP_OKAY);
    rd(ADDR_CTRL1, {24'h0, CTRL1_RST}, RESP_OKAY);
    rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'h0, RESP_SLVERR);
    period(8);
    // every display oscillator type
    for (int i = 0; i < 4; i++)
    begin
      d = {$random(seed)} & 32'hFFFF_FF00 | (i << 1);
      wr(ADDR_DISP, d, RESP_OKAY);
      rd(ADDR_DISP, i << 1, RESP_OKAY);
      check("display type", display_osc_type, i);
    end
    // the undivided ratio and the /2, /4 and /16 ratios with drive select
    wr(ADDR_CTRL0, 32'h0, RESP_OKAY);
    for (int i = 0; i < 4; i++)
    begin
      wr(ADDR_CTRL1, c1_tab[i], RESP_OKAY);
      period(per_tab[i]);
      check("drive", main_osc_drive_high, c1_tab[i][5]);
      rd(ADDR_CTRL1, c1_tab[i], RESP_OKAY);
    end
    // wait with peripheral stop, woken by a request
    wr(ADDR_CTRL1, 32'h80, RESP_OKAY);
    wr(ADDR_CTRL0, 32'h04, RESP_OKAY);
    wr(ADDR_CMD, 32'h01, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("wait", {port_hold, watchdog_run, main_osc_run}, 3'b101);
    check("periph in wait", periph_clk_div1, 1'b0);
    rd(ADDR_STATUS, 32'h1, RESP_OKAY);
    wake();
    check("hold after wake", port_hold, 1'b0);
    period(4);
    // stop, refused wake, then an enabled wake
    wr(ADDR_CTRL0, 32'h0, RESP_OKAY);
    wr(ADDR_CTRL1, 32'h81, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("stop", {port_hold, main_osc_run, watchdog_run}, 3'b100);
    rd(ADDR_CTRL0, 32'h40, RESP_OKAY);
    rd(ADDR_CTRL1, 32'hA0, RESP_OKAY);
    rd(ADDR_STATUS, 32'h2, RESP_OKAY);
    irq_pending <= 1'b1;
    repeat (5) @(posedge aclk);
    check("stop kept", port_hold, 1'b1);
    irq_enabled <= 1'b1;
    wake();
    period(8);
    // main clock stop and restart
    wr(ADDR_CTRL0, 32'h60, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("main off", {main_osc_run, converter_clock}, 2'b00);
    wr(ADDR_CTRL0, 32'h40, RESP_OKAY);
    repeat (2) @(posedge aclk);
    check("main restart", main_osc_run, 1'b1);
    // clock enable low freezes the bus clock, /1 and /8 peripheral, watchdog and oscillator outputs
    ce <= 1'b0;
    @(posedge aclk);
    d = {26'h0, bus_clk_en, bus_clk_level, periph_clk_div1,
         periph_clk_div8, watchdog_run, main_osc_run};
    repeat (5) @(posedge aclk);
    check("frozen", {26'h0, bus_clk_en, bus_clk_level, periph_clk_div1,
          periph_clk_div8, watchdog_run, main_osc_run}, d);
    ce <= 1'b1;
    final_report();
  end
endmodule
`default_nettype wire
